//--- hw/lcdcd_pkg.sv
/*
 * lcdcd_pkg: constants shared by both ends of the LCD command decoder link.
 * Assumes a single 250 MHz system clock on both ends.
 */
package lcdcd_pkg;
    // command opcodes and masks
    localparam logic [7:0] OPC_INVERT = 8'hA6;
    localparam logic [7:0] OPC_ALLON = 8'hA4;
    localparam logic [7:0] OPC_BIAS = 8'hA2;
    localparam logic [7:0] OPC_DISP = 8'hAE;
    localparam logic [7:0] OPC_SAVE = 8'hAC;
    localparam logic [7:0] MASK_LSB1 = 8'hFE;
    localparam logic [7:0] OPC_RMW = 8'hE0;
    localparam logic [7:0] OPC_END = 8'hEE;
    localparam logic [7:0] OPC_COM = 8'hC0;
    localparam logic [7:0] MASK_COM = 8'hF0;
    localparam logic [7:0] OPC_POWER = 8'h28;
    localparam logic [7:0] OPC_RATIO = 8'h20;
    localparam logic [7:0] MASK_TOP5 = 8'hF8;
    localparam logic [7:0] OPC_CONTRAST = 8'h81;
    localparam logic [7:0] OPC_BOOST = 8'hF8;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // field positions
    localparam int COM_BIT = 3;
    // reset values
    localparam logic [5:0] CONTRAST_RST = 6'h20;
    localparam logic [2:0] RATIO_RST = 3'h4;
    localparam logic [1:0] BOOST_RST = 2'h0;
    localparam logic [7:0] COLUMN_RST = 8'h00;
    localparam logic [7:0] COLUMN_STEP = 8'h01;
    // host pacing between bus cycles
    localparam logic [3:0] HOST_GAP = 4'h3;

    // which two-byte command is awaiting its operand
    typedef enum logic [1:0] {LCDCD_OP_NONE, LCDCD_OP_CONTRAST, LCDCD_OP_SAVE,
        LCDCD_OP_BOOST} lcdcd_pend_t;
endpackage

//--- hw/lcdcd_if.sv
/*
 * lcdcd_if: parallel write/read port between host and display controller.
 * Assumes both ends share CLK_SYS; a strobe is one cycle wide.
 */
`timescale 1ns/1ps
interface lcdcd_if;
    logic wr_stb;       // one-cycle write strobe
    logic rd_stb;       // one-cycle read strobe
    logic reg_select;   // 0 command, 1 display data
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport host (output wr_stb, output rd_stb, output reg_select, output wdata,
        input rdata);
    modport dev (input wr_stb, input rd_stb, input reg_select, input wdata,
        output rdata);
endinterface

//--- hw/lcdcd_device.sv
/*
 * lcdcd_device: controller end of the host link. Decodes the upper command
 * set of a 128x64 graphic LCD controller (inversion, all-on, bias,
 * read-modify-write, common direction, power circuit, regulation ratio,
 * contrast, power save and booster level) and steers display data writes
 * and reads to the RAM port instead of the decoder.
 * Assumes the host end paces strobes, never raises both strobes at once and
 * shares CLK_SYS; the display RAM sits outside and RAM_RDATA already holds
 * the byte at COLUMN when a read strobe arrives.
 */
// Operation
// - inverse display bit sets pixel inversion
// - all-pixels bit forces every pixel on
// - bias bit chooses one ninth or seventh
// - read-modify-write: reads hold, writes advance column
// - common direction bit reverses common scan
// - power control latches booster, regulator, follower
// - regulation ratio latches three-bit field
// - contrast level taken from second byte
// - power save: low bit chooses sleep
// - display off plus all-on enters power save
// - booster level taken from second byte
// - host never sends reserved test commands
// - data writes go to display RAM
`timescale 1ns/1ps
module lcdcd_device (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // host link
    lcdcd_if.dev BUS,
    // controller state to the panel logic
    output logic INVERT_BIT,
    output logic ALL_ON_BIT,
    output logic BIAS_CHOICE,
    output logic COMMON_REVERSE,
    output logic BOOSTER_ENABLE,
    output logic REGULATOR_ENABLE,
    output logic FOLLOWER_ENABLE,
    output logic [2:0] REG_RATIO,
    output logic [5:0] CONTRAST_LEVEL,
    output logic [1:0] BOOST_LEVEL,
    output logic SLEEP,
    output logic DISPLAY_ON,
    output logic RMW_MODE,
    output logic [7:0] COLUMN,
    // display RAM write side and read byte
    output logic RAM_WE,
    output logic [7:0] RAM_WDATA,
    input wire logic [7:0] RAM_RDATA
);
    typedef struct packed {
        // single-bit display settings
        logic invert;
        logic all_on;
        logic bias;
        logic com_rev;
        // power circuit, ratio, contrast and booster level
        logic [2:0] power;
        logic [2:0] ratio;
        logic [5:0] contrast;
        logic [1:0] boost;
        // power save and display state
        logic sleep;
        logic disp_on;
        // RAM port and column address
        logic rmw;
        logic [7:0] column;
        logic ram_we;
        logic [7:0] ram_wdata;
        // read byte held until the next data read
        logic [7:0] rdata;
        // operand bookkeeping for two-byte commands
        lcdcd_pkg::lcdcd_pend_t pend;
        logic save_md;
    } lcdcd_dev_t;

    lcdcd_dev_t st;
    lcdcd_dev_t next_st;

    // masked opcode compare, used for the single-bit, common direction, power and ratio families
    function automatic logic hit(input logic [7:0] b, input logic [7:0] mask,
            input logic [7:0] opc);
        hit = (b & mask) == opc;
    endfunction

    // decode one bus cycle; a pending operand byte is never reinterpreted
    always_comb begin
        logic [7:0] b;
        b = BUS.wdata;
        // hold every setting by default; the RAM strobe lasts one cycle
        next_st = st;
        next_st.ram_we = 1'b0;
        // data write: RAM gets the byte, the column always steps
        if (BUS.wr_stb && BUS.reg_select) begin
            next_st.ram_we = 1'b1;
            next_st.ram_wdata = b;
            next_st.column = st.column + lcdcd_pkg::COLUMN_STEP;
        // data read: byte captured from RAM, column steps outside RMW
        end else if (BUS.rd_stb && BUS.reg_select) begin
            next_st.rdata = RAM_RDATA;
            // read-modify-write holds the column so the write lands on it
            if (!st.rmw) begin
                next_st.column = st.column + lcdcd_pkg::COLUMN_STEP;
            end
        // command byte: the operand slot comes first, then the opcode families
        end else if (BUS.wr_stb) begin
            if (st.pend != lcdcd_pkg::LCDCD_OP_NONE) begin
                next_st.pend = lcdcd_pkg::LCDCD_OP_NONE;
                case (st.pend)
                    lcdcd_pkg::LCDCD_OP_CONTRAST: begin
                        // top two operand bits carry nothing and are dropped
                        next_st.contrast = b[5:0];
                    end
                    lcdcd_pkg::LCDCD_OP_SAVE: begin
                        next_st.sleep = !st.save_md;
                    end
                    lcdcd_pkg::LCDCD_OP_BOOST: begin
                        next_st.boost = b[1:0];
                    end
                    default: begin
                        next_st.pend = lcdcd_pkg::LCDCD_OP_NONE;
                    end
                endcase
            // single-byte settings, the low bit is the new value; the power save opener keeps it as the save mode
            end else if (hit(b, lcdcd_pkg::MASK_LSB1, lcdcd_pkg::OPC_INVERT)) begin
                next_st.invert = b[0];
            end else if (hit(b, lcdcd_pkg::MASK_LSB1, lcdcd_pkg::OPC_ALLON)) begin
                next_st.all_on = b[0];
                // all-on while the display is off is the compound sleep entry
                if (b[0] && !st.disp_on) begin
                    next_st.sleep = 1'b1;
                end else if (!b[0]) begin
                    next_st.sleep = 1'b0;
                end
            end else if (hit(b, lcdcd_pkg::MASK_LSB1, lcdcd_pkg::OPC_BIAS)) begin
                next_st.bias = b[0];
            end else if (hit(b, lcdcd_pkg::MASK_LSB1, lcdcd_pkg::OPC_DISP)) begin
                next_st.disp_on = b[0];
                if (!b[0] && st.all_on) begin
                    next_st.sleep = 1'b1;
                end
            end else if (hit(b, lcdcd_pkg::MASK_LSB1, lcdcd_pkg::OPC_SAVE)) begin
                next_st.pend = lcdcd_pkg::LCDCD_OP_SAVE;
                next_st.save_md = b[0];
            // read-modify-write entry and exit are exact bytes
            end else if (b == lcdcd_pkg::OPC_RMW) begin
                next_st.rmw = 1'b1;
            end else if (b == lcdcd_pkg::OPC_END) begin
                next_st.rmw = 1'b0;
            // direction bit is bit 3, in the low nibble, low three bits ignored
            end else if (hit(b, lcdcd_pkg::MASK_COM, lcdcd_pkg::OPC_COM)) begin
                next_st.com_rev = b[lcdcd_pkg::COM_BIT];
            // power and ratio share the top five bits, one bit apart
            end else if (hit(b, lcdcd_pkg::MASK_TOP5, lcdcd_pkg::OPC_POWER)) begin
                next_st.power = b[2:0];
            end else if (hit(b, lcdcd_pkg::MASK_TOP5, lcdcd_pkg::OPC_RATIO)) begin
                next_st.ratio = b[2:0];
            // two-byte openers only note which operand comes next
            end else if (b == lcdcd_pkg::OPC_CONTRAST) begin
                next_st.pend = lcdcd_pkg::LCDCD_OP_CONTRAST;
            end else if (b == lcdcd_pkg::OPC_BOOST) begin
                next_st.pend = lcdcd_pkg::LCDCD_OP_BOOST;
            end
            // other test-space bytes are ignored, the host must not send them
        end
    end

    // state register; one register for all state keeps next value and flops in step
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            // everything clears, then contrast, ratio, boost and column are loaded from their reset constants
            st <= '0;
            st.contrast <= lcdcd_pkg::CONTRAST_RST;
            st.ratio <= lcdcd_pkg::RATIO_RST;
            st.boost <= lcdcd_pkg::BOOST_RST;
            st.column <= lcdcd_pkg::COLUMN_RST;
            st.pend <= lcdcd_pkg::LCDCD_OP_NONE;
        end else begin
            st <= next_st;
        end
    end

    // display settings, straight from flip-flops
    assign INVERT_BIT = st.invert;
    assign ALL_ON_BIT = st.all_on;
    assign BIAS_CHOICE = st.bias;
    assign COMMON_REVERSE = st.com_rev;

    // power circuit enables and analogue levels
    assign BOOSTER_ENABLE = st.power[2];
    assign REGULATOR_ENABLE = st.power[1];
    assign FOLLOWER_ENABLE = st.power[0];
    assign REG_RATIO = st.ratio;
    assign CONTRAST_LEVEL = st.contrast;
    assign BOOST_LEVEL = st.boost;

    // modes and address
    assign SLEEP = st.sleep;
    assign DISPLAY_ON = st.disp_on;
    assign RMW_MODE = st.rmw;
    assign COLUMN = st.column;

    // RAM port and read byte back to the host
    assign RAM_WE = st.ram_we;
    assign RAM_WDATA = st.ram_wdata;
    assign BUS.rdata = st.rdata;
endmodule

//--- hw/lcdcd_host.sv
/*
 * lcdcd_host: host end; turns user requests into single bus cycles and
 * sends both bytes of two-byte commands.
 * Assumes the user holds a request until CMD_READY pulses high with it.
 */
`timescale 1ns/1ps
module lcdcd_host (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // user request
    input wire logic CMD_VALID,
    input wire logic CMD_READ,
    input wire logic CMD_DATA,
    input wire logic CMD_DOUBLE,
    input wire logic [7:0] CMD_BYTE,
    input wire logic [7:0] CMD_OPERAND,
    output logic CMD_READY,
    output logic [7:0] READ_DATA,
    output logic READ_VALID,
    // link to the controller
    lcdcd_if.host BUS
);
    typedef enum logic [1:0] {LCDCD_H_IDLE, LCDCD_H_SECOND, LCDCD_H_WAIT} lcdcd_hst_t;
    typedef struct packed {
        lcdcd_hst_t state;
        logic [3:0] gap;
        logic wr;
        logic rd;
        logic rs;
        logic [7:0] wdata;
        logic [7:0] operand;
        logic rd_wait;
        logic [7:0] rdata;
        logic rvalid;
    } lcdcd_host_t;

    lcdcd_host_t st;
    lcdcd_host_t next_st;

    // reserved test-space commands other than the booster one are refused
    function automatic logic reserved(input logic [7:0] b);
        reserved = (b[7:4] == 4'hF) && (b != lcdcd_pkg::OPC_BOOST);
    endfunction

    // ready only when idle and the byte is not a refused test-space command
    assign CMD_READY = (st.state == LCDCD_H_IDLE) && CMD_VALID
        && !(reserved(CMD_BYTE) && !CMD_DATA);

    // one strobe per cycle, then a gap so bytes are never back to back
    always_comb begin
        next_st = st;
        next_st.wr = 1'b0;
        next_st.rd = 1'b0;
        next_st.rvalid = 1'b0;
        next_st.rd_wait = 1'b0;
        if (st.rd_wait) begin
            next_st.rdata = BUS.rdata;
            next_st.rvalid = 1'b1;
        end
        if (st.rd) begin
            next_st.rd_wait = 1'b1;
        end
        case (st.state)
            LCDCD_H_IDLE: begin
                if (CMD_VALID && !(reserved(CMD_BYTE) && !CMD_DATA)) begin
                    next_st.rs = CMD_DATA;
                    next_st.wdata = CMD_BYTE;
                    next_st.wr = !CMD_READ;
                    next_st.rd = CMD_READ;
                    next_st.operand = CMD_OPERAND;
                    next_st.gap = lcdcd_pkg::HOST_GAP;
                    // two-byte commands send their operand next
                    next_st.state = (CMD_DOUBLE && !CMD_DATA) ? LCDCD_H_SECOND
                        : LCDCD_H_WAIT;
                end
            end
            LCDCD_H_SECOND: begin
                next_st.gap = st.gap - 4'h1;
                if (st.gap == 4'h0) begin
                    next_st.wdata = st.operand;
                    next_st.rs = 1'b0;
                    next_st.wr = 1'b1;
                    next_st.gap = lcdcd_pkg::HOST_GAP;
                    next_st.state = LCDCD_H_WAIT;
                end
            end
            LCDCD_H_WAIT: begin
                next_st.gap = st.gap - 4'h1;
                if (st.gap == 4'h0) begin
                    next_st.state = LCDCD_H_IDLE;
                end
            end
            default: begin
                next_st.state = LCDCD_H_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st <= '0;
            st.state <= LCDCD_H_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign BUS.wr_stb = st.wr;
    assign BUS.rd_stb = st.rd;
    assign BUS.reg_select = st.rs;
    assign BUS.wdata = st.wdata;
    assign READ_DATA = st.rdata;
    assign READ_VALID = st.rvalid;
endmodule

//--- verification/lcdcd_chk.sv
/*
 * lcdcd_chk: assertions on the link between host end and controller end.
 * Assumes one clock shared by both ends and an active-high async reset.
 */
`timescale 1ns/1ps
module lcdcd_chk (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // link signals
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic reg_select,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    // command write with a given byte, and an operand whose masked bits are zero
    sequence s_cmd(logic [7:0] b);
        wr_stb && !reg_select && wdata == b;
    endsequence
    sequence s_arg(logic [7:0] m);
        wr_stb && !reg_select && (wdata & m) == 8'h00;
    endsequence

    property p_no_test;
        wr_stb && !reg_select && wdata[7:4] == 4'hF |-> wdata == lcdcd_pkg::OPC_BOOST;
    endproperty
    a_no_test: assert property (p_no_test) else $error("reserved byte on link");
    property p_one_stb;
        !(wr_stb && rd_stb);
    endproperty
    a_one_stb: assert property (p_one_stb) else $error("both strobes high");
    property p_wr_pulse;
        wr_stb |=> !wr_stb;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    property p_rd_pulse;
        rd_stb |=> !rd_stb;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
    // operands may come late when data cycles sit between the two bytes
    property p_contrast;
        s_cmd(lcdcd_pkg::OPC_CONTRAST) |-> ##[1:60] s_arg(8'hC0);
    endproperty
    a_contrast: assert property (p_contrast) else $error("contrast operand missing");
    property p_save;
        wr_stb && !reg_select && (wdata & lcdcd_pkg::MASK_LSB1) == lcdcd_pkg::OPC_SAVE
            |-> ##[1:60] s_cmd(lcdcd_pkg::BYTE_ZERO);
    endproperty
    a_save: assert property (p_save) else $error("save operand missing");
    property p_boost;
        s_cmd(lcdcd_pkg::OPC_BOOST) |-> ##[1:60] s_arg(8'hFC);
    endproperty
    a_boost: assert property (p_boost) else $error("booster operand missing");
    property p_rdata;
        !$past(rd_stb) |-> $stable(rdata);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read byte moved without read");
endmodule

//--- verification/tb.sv
/*
 * tb: drives the host end's user side, which talks to the controller end.
 * Assumes the display RAM is modelled by a constant read byte.
 */
`timescale 1ns/1ps
module tb;
    logic clk_sys, rst, valid, rd, dat, dbl, ram_we, ready, rvalid;
    logic invert_bit, allon, bias, comr, ben, ren, fen, sleep, don, rmw;
    logic [7:0] byt, opnd, ram_rdata, read_data, column, ram_wdata;
    logic [2:0] ratio;
    logic [5:0] contrast;
    logic [1:0] boost;
    int miscompares, compares, exp_col, we_cnt, rv_cnt, n;
    // command byte and expected flags {inv,allon,bias,comr,sleep,rmw,don,0};
    // all-on is first tried with the display on, so it must not enter sleep
    localparam logic [15:0] TBL [12] = '{16'hA780, 16'hA600, 16'hAF02, 16'hA542, 16'hA402,
        16'hA322, 16'hA202, 16'hC812, 16'hC702, 16'hAE00, 16'hA548, 16'hA400};

    lcdcd_if i_lcdcd_if ();
    lcdcd_host i_lcdcd_host (.CLK_SYS(clk_sys), .RST(rst), .CMD_VALID(valid), .CMD_READ(rd),
        .CMD_DATA(dat), .CMD_DOUBLE(dbl), .CMD_BYTE(byt), .CMD_OPERAND(opnd),
        .CMD_READY(ready), .READ_DATA(read_data), .READ_VALID(rvalid), .BUS(i_lcdcd_if));
    lcdcd_device i_lcdcd_device (.CLK_SYS(clk_sys), .RST(rst), .BUS(i_lcdcd_if),
        .INVERT_BIT(invert_bit), .ALL_ON_BIT(allon), .BIAS_CHOICE(bias), .COMMON_REVERSE(comr),
        .BOOSTER_ENABLE(ben), .REGULATOR_ENABLE(ren), .FOLLOWER_ENABLE(fen),
        .REG_RATIO(ratio), .CONTRAST_LEVEL(contrast), .BOOST_LEVEL(boost), .SLEEP(sleep),
        .DISPLAY_ON(don), .RMW_MODE(rmw), .COLUMN(column), .RAM_WE(ram_we),
        .RAM_WDATA(ram_wdata), .RAM_RDATA(ram_rdata));
    lcdcd_chk i_lcdcd_chk (.CLK_SYS(clk_sys), .RST(rst), .wr_stb(i_lcdcd_if.wr_stb),
        .rd_stb(i_lcdcd_if.rd_stb), .reg_select(i_lcdcd_if.reg_select),
        .wdata(i_lcdcd_if.wdata), .rdata(i_lcdcd_if.rdata));

    // clock, and counts of RAM write and read-valid pulses
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (ram_we === 1'b1) begin
            we_cnt++;
        end
        if (rvalid === 1'b1) begin
            rv_cnt++;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one user request; the settle gap outlasts a double command
    task automatic req(input logic r, input logic d, input logic b2, input logic [7:0] b,
        input logic [7:0] o);
        int k;
        @(negedge clk_sys);
        {valid, rd, dat, dbl, byt, opnd} = {1'b1, r, d, b2, b, o};
        k = 0;
        #1;
        while (ready !== 1'b1 && k < 60) begin
            @(negedge clk_sys);
            #1;
            k++;
        end
        chk({7'h00, ready}, 8'h01, "request not taken");
        @(negedge clk_sys);
        valid = 1'b0;
        repeat (14) @(negedge clk_sys);
    endtask
    function automatic logic [7:0] flags();
        return {invert_bit, allon, bias, comr, sleep, rmw, don, 1'b0};
    endfunction

    // watchdog: the whole sequence needs about 2 us
    initial begin
        #20us;
        miscompares++;
        close_out();
    end

    initial begin
        {rst, valid, rd, dat, dbl, byt, opnd} = {1'b1, 20'h00000};
        {ram_rdata, miscompares, compares, exp_col, we_cnt, rv_cnt} = {8'hC3, 160'h0};
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        chk({contrast, boost}, 8'h80, "reset contrast and boost");
        chk({5'h00, ratio}, 8'h04, "reset ratio");
        // single-byte settings, set then cleared, then the compound save
        for (int i = 0; i < 12; i++) begin
            req(1'b0, 1'b0, 1'b0, TBL[i][15:8], 8'h00);
            chk(flags(), TBL[i][7:0], "flag command");
        end
        req(1'b0, 1'b0, 1'b1, 8'hAC, 8'h00);
        chk(flags(), 8'h08, "save sleep");
        req(1'b0, 1'b0, 1'b1, 8'hAD, 8'h00);
        chk(flags(), 8'h00, "save normal");
        req(1'b0, 1'b0, 1'b0, 8'h2D, 8'h00);
        chk({5'h00, ben, ren, fen}, 8'h05, "power bits");
        req(1'b0, 1'b0, 1'b0, 8'h2A, 8'h00);
        chk({5'h00, ben, ren, fen}, 8'h02, "power bits");
        req(1'b0, 1'b0, 1'b0, 8'h23, 8'h00);
        chk({5'h00, ratio}, 8'h03, "ratio");
        req(1'b0, 1'b0, 1'b1, 8'h81, 8'h3F);
        chk({2'b00, contrast}, 8'h3F, "contrast");
        // a data write between the bytes must not take the operand slot
        req(1'b0, 1'b0, 1'b0, 8'h81, 8'h00);
        req(1'b0, 1'b1, 1'b0, 8'h5A, 8'h00);
        exp_col++;
        chk(ram_wdata, 8'h5A, "ram byte");
        chk(we_cnt[7:0], 8'h01, "ram write pulses");
        req(1'b0, 1'b0, 1'b0, 8'h21, 8'h00);
        chk({2'b00, contrast}, 8'h21, "late operand");
        chk({5'h00, ratio}, 8'h03, "operand not decoded");
        req(1'b0, 1'b0, 1'b1, 8'hF8, 8'h03);
        chk({6'h00, boost}, 8'h03, "booster level");
        req(1'b0, 1'b0, 1'b1, 8'hF8, 8'h01);
        chk({6'h00, boost}, 8'h01, "booster level");
        // reserved byte offered to the host end is never taken
        @(negedge clk_sys);
        {valid, byt, n} = {1'b1, 8'hF5, 32'h0};
        repeat (10) begin
            #1;
            n += (ready === 1'b1) ? 1 : 0;
            @(negedge clk_sys);
        end
        valid = 1'b0;
        chk(n[7:0], 8'h00, "reserved byte taken");
        // read-modify-write: reads hold the column, writes advance it
        req(1'b0, 1'b0, 1'b0, 8'hE0, 8'h00);
        chk(flags(), 8'h04, "rmw entry");
        req(1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
        chk(read_data, 8'hC3, "read byte");
        chk(rv_cnt[7:0], 8'h01, "read valid pulses");
        chk(column, exp_col[7:0], "column after rmw read");
        req(1'b0, 1'b1, 1'b0, 8'h11, 8'h00);
        exp_col++;
        chk(column, exp_col[7:0], "column after rmw write");
        req(1'b0, 1'b0, 1'b0, 8'hEE, 8'h00);
        req(1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
        exp_col++;
        chk(column, exp_col[7:0], "column after plain read");
        chk(rv_cnt[7:0], 8'h02, "read valid pulses");
        chk(flags(), 8'h00, "rmw exit");
        close_out();
    end
endmodule
